/* logic/modem_pkg.sv */
// Shared constants and types for the modem reset, wake and interrupt link
package modem_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int INIT_MAX_US = 1000;
  localparam int INIT_MAX_CYC = CLK_HZ / 1_000_000 * INIT_MAX_US;
  localparam int CLKOUT_SLOW_HZ = 32_787;
  localparam int CLKOUT_FAST_HZ = 4_000_000;
  localparam logic [9:0] SLOW_HALF = 10'(CLK_HZ / (2 * CLKOUT_SLOW_HZ));
  localparam logic [9:0] FAST_HALF = 10'(CLK_HZ / (2 * CLKOUT_FAST_HZ));
  localparam int SCLK_MAX_HZ = 8_000_000;
  localparam int SCLK_HALF_MIN =
    (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  localparam int HOST_RST_HOLD = 8;
  localparam int FRAME_BITS = 16;
  // ==========================================================
  // Registers behind the serial port
  localparam logic [6:0] REG_IRQ_STS = 7'h00;
  localparam logic [6:0] REG_IRQ_MASK = 7'h01;
  localparam logic [6:0] REG_XTAL_TRIM = 7'h02;
  localparam logic [6:0] REG_CLK_CTRL = 7'h03;
  localparam logic [7:0] IRQ_MASK_RST = 8'h00;
  localparam logic [7:0] XTAL_TRIM_RST = 8'h80;
  localparam int WAKE_BIT = 0;
  localparam int CLK_EN_BIT = 0;
  localparam int CLK_SLOW_BIT = 1;
  // ==========================================================
  // State machines
  typedef enum logic [2:0] {
    D_OFF = 3'b001,
    D_INIT = 3'b010,
    D_IDLE = 3'b100
  } dev_state_t;
  typedef enum logic [6:0] {
    H_PINS = 7'b0000001,
    H_CFG = 7'b0000010,
    H_RST = 7'b0000100,
    H_WAIT = 7'b0001000,
    H_READY = 7'b0010000,
    H_XFER = 7'b0100000,
    H_GAP = 7'b1000000
  } host_state_t;
endpackage : modem_pkg

/* logic/modem_link_if.sv */
// Pin-level link between the host controller and the modem
`timescale 1ns/1ps
interface modem_link_if;
  logic rst_o;
  logic rst_oe;
  logic rst_n;
  logic strap;
  logic sclk;
  logic mosi;
  logic ssel_n;
  logic miso_o;
  logic miso_oe;
  logic miso;
  logic irq_n;
  logic clk_out;
  // Undriven pins float high through pull-ups
  assign rst_n = rst_oe ? rst_o : 1'b1;
  assign miso = miso_oe ? miso_o : 1'b1;
  modport host (
    output rst_o, rst_oe, strap, sclk, mosi, ssel_n,
    input miso, irq_n, clk_out
  );
  modport modem (
    input rst_n, strap, sclk, mosi, ssel_n,
    output miso_o, miso_oe, irq_n, clk_out
  );
endinterface : modem_link_if

/* logic/modem_end.sv */
// Modem end: reset capture, power-up sequence, wake interrupt, clock out
`timescale 1ns/1ps
module modem_end #(
  parameter int INIT_CYCLES = modem_pkg::INIT_MAX_CYC - 8
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  modem_link_if.modem link,
  output logic o_idle,
  output logic [7:0] o_osc_code
);
  import modem_pkg::*;

  if (INIT_CYCLES < 1 || INIT_CYCLES > INIT_MAX_CYC - 4) begin : g_bad
    $error("INIT_CYCLES out of range");
  end

  // ==========================================================
  // Pin capture
  logic rst_q1;
  logic rst_q2;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic sclk_prev;
  logic hold;
  logic sclk_rise;
  logic ssel_act;
  logic mosi_s;
  logic strap_s;

  // Assert at once, release through two flops
  always_ff @(posedge i_clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      rst_q1 <= 1'b0;
      rst_q2 <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_q2 <= rst_q1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sync1 <= 4'hF;
      sync2 <= 4'hF;
      sclk_prev <= 1'b1;
    end else begin
      sync1 <= {link.strap, link.ssel_n, link.mosi, link.sclk};
      sync2 <= sync1;
      sclk_prev <= sync2[0];
    end
  end

  assign hold = !rst_q2 || !i_reset_n;
  assign sclk_rise = sync2[0] && !sclk_prev;
  assign ssel_act = !sync2[2];
  assign mosi_s = sync2[1];
  assign strap_s = sync2[3];

  // ==========================================================
  // Power-up sequence
  dev_state_t state;
  dev_state_t next_state;
  logic [15:0] init_cnt;
  logic [15:0] next_init_cnt;
  logic strap_slow;
  logic next_strap_slow;
  logic enter_idle;

  always_comb begin
    next_state = state;
    next_init_cnt = init_cnt;
    next_strap_slow = strap_slow;
    enter_idle = 1'b0;
    if (hold) begin
      next_state = D_OFF;
      next_init_cnt = 16'h0000;
      next_strap_slow = strap_s;
    end else begin
      unique case (state)
        D_OFF: begin
          next_state = D_INIT;
        end
        D_INIT: begin
          next_init_cnt = init_cnt + 16'h0001;
          if (init_cnt == 16'(INIT_CYCLES - 1)) begin
            next_state = D_IDLE;
            enter_idle = 1'b1;
          end
        end
        D_IDLE: begin
          next_state = D_IDLE;
        end
        default: begin
          next_state = D_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state <= D_OFF;
      init_cnt <= 16'h0000;
      strap_slow <= 1'b0;
    end else begin
      state <= next_state;
      init_cnt <= next_init_cnt;
      strap_slow <= next_strap_slow;
    end
  end

  // ==========================================================
  // Serial slave: rw bit, 7-bit address, 8-bit data, MSB first
  logic [4:0] bit_cnt;
  logic [4:0] next_bit_cnt;
  logic [14:0] shift_in;
  logic [14:0] next_shift_in;
  logic [7:0] shift_out;
  logic [7:0] next_shift_out;
  logic miso_q;
  logic next_miso;
  logic miso_oe_q;
  logic next_miso_oe;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] reg_rd;
  logic [7:0] irq_sts;
  logic [7:0] irq_mask;
  logic [7:0] xtal_trim;
  logic [7:0] clk_ctrl;

  always_comb begin
    case (rd_addr)
      REG_IRQ_STS: reg_rd = irq_sts;
      REG_IRQ_MASK: reg_rd = irq_mask;
      REG_XTAL_TRIM: reg_rd = xtal_trim;
      REG_CLK_CTRL: reg_rd = clk_ctrl;
      default: reg_rd = 8'h00;
    endcase
  end

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_miso = miso_q;
    next_miso_oe = (state == D_IDLE) && ssel_act;
    wr_en = 1'b0;
    wr_addr = shift_in[13:7];
    wr_data = {shift_in[6:0], mosi_s};
    rd_addr = {shift_in[5:0], mosi_s};
    if (state != D_IDLE || !ssel_act) begin
      next_bit_cnt = 5'h00;
      next_miso = 1'b0;
    end else if (sclk_rise && bit_cnt != 5'(FRAME_BITS)) begin
      next_bit_cnt = bit_cnt + 5'h01;
      next_shift_in = {shift_in[13:0], mosi_s};
      next_shift_out = {shift_out[6:0], 1'b0};
      next_miso = shift_out[6];
      if (bit_cnt == 5'h07) begin
        next_shift_out = shift_in[6] ? reg_rd : 8'h00;
        next_miso = next_shift_out[7];
      end
      if (bit_cnt == 5'(FRAME_BITS - 1)) begin
        wr_en = !shift_in[14];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      bit_cnt <= 5'h00;
      shift_in <= 15'h0000;
      shift_out <= 8'h00;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      miso_q <= next_miso;
      miso_oe_q <= next_miso_oe;
    end
  end

  // ==========================================================
  // Status, mask, trim and clock control
  logic [7:0] next_sts;
  logic [7:0] next_mask;
  logic [7:0] next_trim;
  logic [7:0] next_clk_ctrl;
  logic [7:0] osc_code;
  logic [7:0] next_osc_code;
  logic irq_n_q;
  logic next_irq_n;

  always_comb begin
    next_sts = irq_sts;
    next_mask = irq_mask;
    next_trim = xtal_trim;
    next_clk_ctrl = clk_ctrl;
    if (state != D_IDLE) begin
      next_sts = 8'h00;
      next_mask = IRQ_MASK_RST;
      next_trim = XTAL_TRIM_RST;
      next_clk_ctrl = {6'h00, strap_slow, 1'b1};
    end else if (wr_en) begin
      case (wr_addr)
        REG_IRQ_STS: next_sts = irq_sts & ~wr_data;
        REG_IRQ_MASK: next_mask = wr_data;
        REG_XTAL_TRIM: next_trim = wr_data;
        REG_CLK_CTRL: next_clk_ctrl = wr_data;
        default: next_sts = irq_sts;
      endcase
    end
    // Set after clear so a wake event is never lost
    if (enter_idle) begin
      next_sts[WAKE_BIT] = 1'b1;
    end
    // Oscillator speeds up with this code, so trim runs opposite
    next_osc_code = ~next_trim;
    next_irq_n = ~|(next_sts & ~next_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      irq_sts <= 8'h00;
      irq_mask <= IRQ_MASK_RST;
      xtal_trim <= XTAL_TRIM_RST;
      clk_ctrl <= 8'h01;
      osc_code <= ~XTAL_TRIM_RST;
      irq_n_q <= 1'b1;
    end else begin
      irq_sts <= next_sts;
      irq_mask <= next_mask;
      xtal_trim <= next_trim;
      clk_ctrl <= next_clk_ctrl;
      osc_code <= next_osc_code;
      irq_n_q <= next_irq_n;
    end
  end

  // ==========================================================
  // Reference clock output divider
  logic [9:0] div_cnt;
  logic [9:0] next_div_cnt;
  logic [9:0] half;
  logic clk_q;
  logic next_clk;

  always_comb begin
    half = clk_ctrl[CLK_SLOW_BIT] ? SLOW_HALF : FAST_HALF;
    next_div_cnt = div_cnt + 10'h001;
    next_clk = clk_q;
    if (state != D_IDLE || !clk_ctrl[CLK_EN_BIT]) begin
      next_div_cnt = 10'h000;
      next_clk = 1'b0;
    end else if (div_cnt >= half - 10'h001) begin
      // At or past the end, so a rate change never runs away
      next_div_cnt = 10'h000;
      next_clk = ~clk_q;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      div_cnt <= 10'h000;
      clk_q <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      clk_q <= next_clk;
    end
  end

  assign link.miso_o = miso_q;
  // Gated by the async reset path so pins go quiet at once, not an edge later
  assign link.miso_oe = miso_oe_q && !hold;
  assign link.irq_n = irq_n_q || hold;
  assign link.clk_out = clk_q && !hold;
  assign o_idle = (state == D_IDLE);
  assign o_osc_code = osc_code;
endmodule : modem_end

/* logic/modem_host.sv */
// Host end: modem reset pin, strap drive, serial master, ready tracking
`timescale 1ns/1ps
module modem_host #(
  parameter int SCLK_HALF = 4,
  parameter int RST_HOLD = modem_pkg::HOST_RST_HOLD
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  modem_link_if.host link,
  input wire logic i_modem_reset,
  input wire logic i_strap_slow,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic [6:0] i_req_addr,
  input wire logic [7:0] i_req_wdata,
  output logic o_req_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic o_modem_ready,
  output logic o_irq
);
  import modem_pkg::*;

  if (SCLK_HALF < SCLK_HALF_MIN || SCLK_HALF > 255 ||
      RST_HOLD < 1 || RST_HOLD > 255) begin : g_bad
    $error("SCLK_HALF or RST_HOLD out of range");
  end

  // ==========================================================
  // Pin capture
  logic [1:0] sync1;
  logic [1:0] sync2;

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      sync1 <= 2'h3;
      sync2 <= 2'h3;
    end else begin
      sync1 <= {link.miso, link.irq_n};
      sync2 <= sync1;
    end
  end

  // ==========================================================
  // Sequencer and serial master
  host_state_t state;
  host_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic rst_oe;
  logic next_rst_oe;
  logic rst_o;
  logic next_rst_o;
  logic ssel_q;
  logic next_ssel;
  logic sclk_q;
  logic next_sclk;
  logic mosi_q;
  logic next_mosi;
  logic [15:0] tx;
  logic [15:0] next_tx;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [4:0] bits;
  logic [4:0] next_bits;
  logic rsp_valid;
  logic next_rsp_valid;
  logic [7:0] rsp_data;
  logic [7:0] next_rsp_data;
  logic strap_q;
  logic busy;

  assign busy = (state == H_XFER) || (state == H_GAP);

  always_comb begin
    next_state = state;
    next_cnt = cnt + 8'h01;
    next_rst_oe = rst_oe;
    next_rst_o = rst_o;
    next_ssel = ssel_q;
    next_sclk = sclk_q;
    next_mosi = mosi_q;
    next_tx = tx;
    next_rx = rx;
    next_bits = bits;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    if (i_modem_reset && !busy) begin
      next_state = H_CFG;
      next_rst_oe = 1'b1;
      next_rst_o = 1'b1;
    end else begin
      unique case (state)
        H_PINS, H_WAIT: begin
          if (state == H_WAIT && !sync2[0]) begin
            next_state = H_READY;
          end
        end
        H_CFG: begin
          next_state = H_RST;
          next_rst_o = 1'b0;
          next_cnt = 8'h00;
        end
        H_RST: begin
          if (cnt == 8'(RST_HOLD - 1)) begin
            next_state = H_WAIT;
            next_rst_o = 1'b1;
          end
        end
        H_READY: begin
          if (i_req_valid) begin
            next_state = H_XFER;
            next_tx = {!i_req_write, i_req_addr, i_req_wdata};
            next_mosi = !i_req_write;
            next_ssel = 1'b0;
            next_bits = 5'h00;
            next_cnt = 8'h00;
          end
        end
        H_XFER: begin
          if (cnt == 8'(SCLK_HALF - 1)) begin
            next_cnt = 8'h00;
            next_sclk = !sclk_q;
            if (!sclk_q) begin
              next_rx = {rx[6:0], sync2[1]};
              next_bits = bits + 5'h01;
            end else if (bits == 5'(FRAME_BITS)) begin
              next_state = H_GAP;
              next_ssel = 1'b1;
              next_rsp_valid = 1'b1;
              next_rsp_data = rx;
            end else begin
              next_tx = {tx[14:0], 1'b0};
              next_mosi = tx[14];
            end
          end
        end
        H_GAP: begin
          // Lets the modem see select high between frames
          if (cnt == 8'(SCLK_HALF - 1)) begin
            next_state = H_READY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      state <= H_PINS;
      cnt <= 8'h00;
      rst_oe <= 1'b0;
      rst_o <= 1'b1;
      ssel_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
      tx <= 16'h0000;
      rx <= 8'h00;
      bits <= 5'h00;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      strap_q <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rst_oe <= next_rst_oe;
      rst_o <= next_rst_o;
      ssel_q <= next_ssel;
      sclk_q <= next_sclk;
      mosi_q <= next_mosi;
      tx <= next_tx;
      rx <= next_rx;
      bits <= next_bits;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      strap_q <= i_strap_slow;
    end
  end

  assign link.rst_oe = rst_oe;
  assign link.rst_o = rst_o;
  assign link.strap = strap_q;
  assign link.sclk = sclk_q;
  assign link.mosi = mosi_q;
  assign link.ssel_n = ssel_q;
  assign o_req_ready = (state == H_READY) && !i_modem_reset;
  assign o_rsp_valid = rsp_valid;
  assign o_rsp_data = rsp_data;
  assign o_modem_ready = (state == H_READY) || busy;
  assign o_irq = !sync2[0];
endmodule : modem_host

/* tb/modem_link_checker.sv */
// Checker for the pin-level link between host and modem ends
`timescale 1ns/1ps
module modem_link_checker
  import modem_pkg::*;
#(
  parameter int INIT_CYCLES = 20
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic rst_n,
  input wire logic strap,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ssel_n,
  input wire logic miso_oe,
  input wire logic irq_n,
  input wire logic clk_out
);
  localparam int HALF_LIM = 620;
  localparam int INIT_LIM = INIT_CYCLES + 10;
  logic clk_q, sclk_q, seen_tog, pulsed, strap_kept;
  logic [9:0] half_cnt;
  logic [4:0] rise_cnt;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // Helper state
  // Rate is judged only after a pin reset, so the kept strap is known
  always_ff @(posedge i_clk_sys) begin
    clk_q <= clk_out;
    sclk_q <= sclk;
    half_cnt <= (clk_out != clk_q) ? 10'h000 : half_cnt + 10'h001;
    seen_tog <= i_reset_n && rst_n && (seen_tog || clk_out != clk_q);
    pulsed <= i_reset_n && (pulsed || !rst_n);
    if (!rst_n) begin
      strap_kept <= strap;
    end
    rise_cnt <= ssel_n ? 5'h00 : rise_cnt + 5'(sclk && !sclk_q);
  end
  // ==========================================================
  // Assertions
  AST_RESET_QUIET: assert property (!rst_n |-> !clk_out && !miso_oe && irq_n)
    else $error("modem active while its reset pin is low");
  AST_INIT_HOLD: assert property ($rose(rst_n) |-> irq_n [*8])
    else $error("interrupt before initialisation ended");
  AST_WAKE_IRQ: assert property ($rose(rst_n) |-> ##[1:INIT_LIM] !irq_n)
    else $error("no wake interrupt in time after reset release");
  AST_CLK_START: assert property ($fell(irq_n) |-> ##[1:HALF_LIM] (clk_out != clk_q))
    else $error("clock output did not start after idle");
  AST_CLK_RATE: assert property ((clk_out != clk_q) && seen_tog && pulsed && rst_n |-> half_cnt == (strap_kept ? SLOW_HALF : FAST_HALF) - 10'h001)
    else $error("clock output half period wrong for strap");
  AST_IRQ_W1C: assert property ($rose(irq_n) && rst_n |-> !$past(ssel_n, 2))
    else $error("interrupt released outside a serial write");
  AST_MISO_OFF: assert property (ssel_n [*5] |-> !miso_oe)
    else $error("serial output driven while not selected");
  AST_SCLK_MIN: assert property ($changed(sclk) |=> $stable(sclk) [*2])
    else $error("serial clock phase too short");
  AST_FRAME_LEN: assert property ($rose(ssel_n) |-> rise_cnt == 5'h10)
    else $error("frame did not carry sixteen clock rises");
  AST_MOSI_HOLD: assert property (sclk && !ssel_n |-> $stable(mosi))
    else $error("data changed while serial clock high");
endmodule : modem_link_checker

/* tb/tb_top.sv */
// Testbench: host and modem ends joined over the pin-level link
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
  err_count++; $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); \
  end end
module tb_top;
  import modem_pkg::*;
  localparam int INIT_N = 20;
  logic i_clk_sys = 1'b0;
  logic i_reset_n = 1'b0;
  logic mrst = 1'b0;
  logic strap_s = 1'b0;
  logic rv = 1'b0;
  logic rw = 1'b0;
  logic [6:0] ra = 7'h00;
  logic [7:0] rwd = 8'h00;
  logic rdy, rsv, mrdy, irq, idle;
  logic [7:0] rsd, osc;
  int err_count = 0;
  int n_tests = 0;
  modem_link_if link();
  modem_end #(.INIT_CYCLES(INIT_N)) i_modem_end (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(link),
    .o_idle(idle), .o_osc_code(osc));
  // Short reset hold shows that a brief pin pulse is enough
  modem_host #(.SCLK_HALF(4), .RST_HOLD(2)) i_modem_host (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .link(link),
    .i_modem_reset(mrst), .i_strap_slow(strap_s), .i_req_valid(rv),
    .i_req_write(rw), .i_req_addr(ra), .i_req_wdata(rwd),
    .o_req_ready(rdy), .o_rsp_valid(rsv), .o_rsp_data(rsd),
    .o_modem_ready(mrdy), .o_irq(irq));
  modem_link_checker #(.INIT_CYCLES(INIT_N)) i_modem_link_checker (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .rst_n(link.rst_n),
    .strap(link.strap), .sclk(link.sclk), .mosi(link.mosi),
    .ssel_n(link.ssel_n), .miso_oe(link.miso_oe), .irq_n(link.irq_n),
    .clk_out(link.clk_out));
  initial forever #12.5 i_clk_sys = ~i_clk_sys;
  // ==========================================================
  // Expectations
  function automatic logic [7:0] ctrl_exp(input logic slow);
    return {6'h00, slow, 1'b1};
  endfunction : ctrl_exp
  function automatic logic [9:0] half_exp(input logic slow);
    return slow ? SLOW_HALF : FAST_HALF;
  endfunction : half_exp
  // ==========================================================
  // Tasks
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // Flags are read at the falling edge, clear of the launching edge
  task automatic wait_hi(input int sel, input int lim);
    int k;
    logic f;
    k = 0;
    f = 1'b0;
    while (f !== 1'b1) begin
      @(negedge i_clk_sys);
      f = (sel == 0) ? rdy : (sel == 1) ? rsv : mrdy;
      k++;
      if (k > lim) begin
        err_count++;
        report_and_stop();
      end
    end
  endtask : wait_hi
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    rv <= 1'b1;
    rw <= w;
    ra <= a;
    rwd <= d;
    wait_hi(0, 3000);
    @(posedge i_clk_sys);
    rv <= 1'b0;
    wait_hi(1, 300);
    q = rsd;
    @(posedge i_clk_sys);
  endtask : xfer
  task automatic measure_half(output logic [9:0] n);
    logic c;
    int k;
    for (int p = 0; p < 2; p++) begin
      c = link.clk_out;
      k = 0;
      while (link.clk_out === c && k < 2000) begin
        @(negedge i_clk_sys);
        k++;
      end
    end
    if (k >= 2000) begin
      err_count++;
      report_and_stop();
    end
    n = 10'(k);
    @(posedge i_clk_sys);
  endtask : measure_half
  // ==========================================================
  // Main sequence
  initial begin
    logic [7:0] rd;
    logic [7:0] t;
    logic [6:0] a;
    logic [9:0] h;
    void'($urandom(5763));
    repeat (3) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    for (int s = 1; s >= 0; s--) begin
      strap_s <= s[0];
      repeat (4) @(posedge i_clk_sys);
      mrst <= 1'b1;
      @(posedge i_clk_sys);
      mrst <= 1'b0;
      repeat (3) @(negedge i_clk_sys);
      `CHK(idle, 1'b0)
      wait_hi(2, 2000);
      `CHK(irq, 1'b1)
      `CHK(idle, 1'b1)
      @(posedge i_clk_sys);
      xfer(1'b0, REG_IRQ_STS, 8'h00, rd);
      `CHK(rd, 8'h01)
      xfer(1'b0, REG_IRQ_MASK, 8'h00, rd);
      `CHK(rd, IRQ_MASK_RST)
      xfer(1'b0, REG_CLK_CTRL, 8'h00, rd);
      `CHK(rd, ctrl_exp(s[0]))
      measure_half(h);
      `CHK(h, half_exp(s[0]))
      xfer(1'b1, REG_IRQ_STS, 8'h00, rd);
      repeat (4) @(negedge i_clk_sys);
      `CHK(irq, 1'b1)
      @(posedge i_clk_sys);
      xfer(1'b1, REG_IRQ_STS, 8'h01, rd);
      repeat (4) @(negedge i_clk_sys);
      `CHK(irq, 1'b0)
      @(posedge i_clk_sys);
      xfer(1'b0, REG_XTAL_TRIM, 8'h00, rd);
      `CHK(rd, XTAL_TRIM_RST)
      for (int i = 0; i < 4; i++) begin
        t = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
        xfer(1'b1, REG_XTAL_TRIM, t, rd);
        xfer(1'b0, REG_XTAL_TRIM, 8'h00, rd);
        `CHK(rd, t)
        @(negedge i_clk_sys);
        `CHK(osc, ~t)
        @(posedge i_clk_sys);
      end
      a = 7'h04 + 7'($urandom_range(123));
      xfer(1'b1, a, 8'($urandom), rd);
      xfer(1'b0, a, 8'h00, rd);
      `CHK(rd, 8'h00)
    end
    report_and_stop();
  end
endmodule : tb_top
